// *** rtl/rrs_sequencer.sv ***
// Functional notes
// - Six reset causes: supply, command, pin pulse, transceiver reset, doze, deep sleep.
// - Registers form four groups: common, sample interface, low band, high band.
// - Power-on and chip reset clear all; per-trx causes one; deep sleep spares common.
// - Supply falling out of range then returning starts a power-on reset.
// - Power-up enables oscillator and digital regulator and defaults all registers.
// - After the power-up delay the clock output is enabled at its default rate.
// - Control port enabled only in radio-off; host waits for that.
// - Reaching radio-off after power-up sets both wake flags and raises interrupt.
// - Writing 0x07 to the command field causes a full chip reset.
// - Chip reset enters an internal reset state, then settles in radio-off.
// - Chip reset completion raises both wake flags.
// - Sleep logic switches both analog supplies off and on.
// - Interrupt pin combines events of both radios and basebands.
// - Transceiver reset clears its group only, reaches radio-off, sets its wake flag.
// - Only command value 0x7 resets; other values do nothing.
module rrs_sequencer
	import rrs_pkg::*;
#(
	parameter int POWER_UP_CYCLES  = rrs_pkg::POWER_UP_CYC,
	parameter int CHIP_RESET_CYCLES = rrs_pkg::CHIP_RESET_CYC,
	parameter int TRX_RESET_CYCLES  = rrs_pkg::TRX_RESET_CYC
)
(
	// Clock and reset.
	input  wire logic                                  i_sys_clk,
	input  wire logic                                  i_sys_rst,
	// Supply monitor and reset pin.
	input  wire logic                                  i_supply_ok,
	input  wire logic                                  i_hard_reset_in_low,
	// Chip reset command write.
	input  wire logic                                  i_chip_reset_wr,
	input  wire logic [rrs_pkg::CHIP_RESET_CMD_W-1:0]  i_chip_reset_command_field,
	// Transceiver commands and sleep requests.
	input  wire logic [rrs_pkg::TRX_COUNT-1:0]         i_trx_reset_cmd,
	input  wire logic [rrs_pkg::TRX_COUNT-1:0]         i_doze_req,
	input  wire logic                                  i_deep_sleep_req,
	// Interrupt sources and flag clear.
	input  wire logic [3:0]                            i_radio_events,
	input  wire logic [rrs_pkg::TRX_COUNT-1:0]         i_wake_clear,
	// Power and clock controls.
	output logic                                       o_crystal_oscillator_en,
	output logic                                       o_digital_regulator_en,
	output logic                                       o_clock_out_en,
	output logic                                       o_analog_supply_low_band_en,
	output logic                                       o_analog_supply_high_band_en,
	// Register group clears.
	output logic                                       o_common_grp_clear,
	output logic                                       o_sample_if_grp_clear,
	output logic                                       o_low_band_grp_clear,
	output logic                                       o_high_band_grp_clear,
	// Host facing status.
	output logic                                       o_ctrl_port_en,
	output logic [rrs_pkg::TRX_COUNT-1:0]              o_wake_done_flag,
	output logic                                       o_irq
);
	import rrs_pkg::*;
	localparam int MAX_CYC = (POWER_UP_CYCLES > CHIP_RESET_CYCLES) ? POWER_UP_CYCLES : CHIP_RESET_CYCLES;
	localparam int CNT_W   = $clog2(MAX_CYC + 1);
	function automatic logic at_last(input logic [CNT_W-1:0] cnt, input int cycles);
		at_last = (cnt == CNT_W'(cycles - 1));
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	rrs_chip_t                       chip_reg;
	logic [CNT_W-1:0]                cnt_reg;
	rrs_trx_t                        trx_reg [TRX_COUNT];
	logic [TRX_CNT_W-1:0]            tcnt_reg [TRX_COUNT];
	logic                            pin_s1_reg;
	logic                            pin_s2_reg;
	logic                            cmd_hit_reg;
	logic [TRX_COUNT-1:0]            wake_reg;
	logic [TRX_COUNT-1:0]            trx_done;
	logic [GRP_COUNT-1:0]            grp_clear_next;
	logic                            pin_low_sync;
	logic                            chip_done;
	logic                            deep_active;
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			pin_s1_reg <= PIN_IDLE_RST;
			pin_s2_reg <= PIN_IDLE_RST;
		end
		else
		begin
			pin_s1_reg <= i_hard_reset_in_low;
			pin_s2_reg <= pin_s1_reg;
		end
	end
	assign pin_low_sync = !pin_s2_reg;

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			cmd_hit_reg <= 1'b0;
		else
			cmd_hit_reg <= i_chip_reset_wr && (chip_reg == RRS_RUNNING)
				&& (i_chip_reset_command_field == CHIP_RESET_CMD);
	end
	assign chip_done = ((chip_reg == RRS_POWER_UP) && at_last(cnt_reg, POWER_UP_CYCLES))
		|| ((chip_reg == RRS_IN_RESET) && !pin_low_sync && at_last(cnt_reg, CHIP_RESET_CYCLES));
	assign deep_active = i_deep_sleep_req && (chip_reg == RRS_RUNNING);
	////////////////////////////////////////////////////////////////////////////////
	// supply loss restarts
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst || !i_supply_ok)
		begin
			chip_reg <= RRS_POWER_OFF;
			cnt_reg  <= '0;
		end
		else
		begin
			unique case (chip_reg)
				RRS_POWER_OFF:
					chip_reg <= RRS_POWER_UP;
				RRS_POWER_UP:
				begin
					if (chip_done)
						chip_reg <= RRS_RUNNING;
					else
						cnt_reg <= cnt_reg + 1'b1;
				end
				RRS_IN_RESET:
				begin
					// The count restarts while the pin is held, so it times from release.
					if (pin_low_sync)
						cnt_reg <= '0;
					else if (chip_done)
						chip_reg <= RRS_RUNNING;
					else
						cnt_reg <= cnt_reg + 1'b1;
				end
				RRS_RUNNING:
				begin
					if (cmd_hit_reg || pin_low_sync)
					begin
						chip_reg <= RRS_IN_RESET;
						cnt_reg  <= '0;
					end
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// transceiver reset
	always_ff @(posedge i_sys_clk)
	begin
		for (int n = 0; n < TRX_COUNT; n++)
		begin
			if (i_sys_rst || (chip_reg != RRS_RUNNING))
			begin
				trx_reg[n]  <= RRS_TRX_RADIO_OFF;
				tcnt_reg[n] <= '0;
			end
			else
			begin
				unique case (trx_reg[n])
					RRS_TRX_RADIO_OFF:
					begin
						tcnt_reg[n] <= '0;
						if (i_trx_reset_cmd[n])
							trx_reg[n] <= RRS_TRX_RESET;
						else if (i_doze_req[n] || deep_active)
							trx_reg[n] <= RRS_TRX_DOZE;
					end
					RRS_TRX_RESET:
					begin
						if (trx_done[n])
						begin
							trx_reg[n]  <= RRS_TRX_RADIO_OFF;
							tcnt_reg[n] <= '0;
						end
						else
							tcnt_reg[n] <= tcnt_reg[n] + 1'b1;
					end
					RRS_TRX_DOZE:
					begin
						if (!(i_doze_req[n] || deep_active))
							trx_reg[n] <= RRS_TRX_RADIO_OFF;
					end
					default:
						trx_reg[n] <= RRS_TRX_RADIO_OFF;
				endcase
			end
		end
	end

	always_comb
	begin
		for (int n = 0; n < TRX_COUNT; n++)
			trx_done[n] = (trx_reg[n] == RRS_TRX_RESET) && (tcnt_reg[n] == TRX_CNT_W'(TRX_RESET_CYCLES - 1));
	end
	////////////////////////////////////////////////////////////////////////////////
	// wake flags, set wins
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			wake_reg <= WAKE_FLAGS_RST;
		else if (chip_done)
			wake_reg <= WAKE_FLAGS_SET;
		else if (chip_reg != RRS_RUNNING)
			wake_reg <= WAKE_FLAGS_RST;
		else
			wake_reg <= trx_done | (wake_reg & ~i_wake_clear);
	end
	always_comb
	begin
		grp_clear_next                = '0;
		grp_clear_next[GRP_COMMON]    = (chip_reg != RRS_RUNNING);
		grp_clear_next[GRP_SAMPLE_IF] = (chip_reg != RRS_RUNNING) || deep_active;
		grp_clear_next[GRP_LOW_BAND]  = (chip_reg != RRS_RUNNING) || (trx_reg[0] != RRS_TRX_RADIO_OFF);
		grp_clear_next[GRP_HIGH_BAND] = (chip_reg != RRS_RUNNING) || (trx_reg[1] != RRS_TRX_RADIO_OFF);
	end
	// Every output but o_wake_done_flag is registered here, so those pins follow the state with one cycle of lag.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			o_crystal_oscillator_en      <= 1'b0;
			o_digital_regulator_en       <= 1'b0;
			o_clock_out_en               <= 1'b0;
			o_analog_supply_low_band_en  <= 1'b0;
			o_analog_supply_high_band_en <= 1'b0;
			o_common_grp_clear           <= 1'b1;
			o_sample_if_grp_clear        <= 1'b1;
			o_low_band_grp_clear         <= 1'b1;
			o_high_band_grp_clear        <= 1'b1;
			o_ctrl_port_en               <= 1'b0;
			o_irq                        <= 1'b0;
		end
		else
		begin
			o_crystal_oscillator_en      <= (chip_reg != RRS_POWER_OFF);
			o_digital_regulator_en       <= (chip_reg != RRS_POWER_OFF);
			o_clock_out_en               <= (chip_reg == RRS_RUNNING) || (chip_reg == RRS_IN_RESET);
			o_analog_supply_low_band_en  <= (chip_reg == RRS_RUNNING) && (trx_reg[0] != RRS_TRX_DOZE);
			o_analog_supply_high_band_en <= (chip_reg == RRS_RUNNING) && (trx_reg[1] != RRS_TRX_DOZE);
			o_common_grp_clear           <= grp_clear_next[GRP_COMMON];
			o_sample_if_grp_clear        <= grp_clear_next[GRP_SAMPLE_IF];
			o_low_band_grp_clear         <= grp_clear_next[GRP_LOW_BAND];
			o_high_band_grp_clear        <= grp_clear_next[GRP_HIGH_BAND];
			o_ctrl_port_en               <= (chip_reg == RRS_RUNNING);
			o_irq                        <= (|wake_reg) || (|i_radio_events);
		end
	end
	assign o_wake_done_flag = wake_reg;
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_power_up_end;
		(chip_reg == RRS_POWER_UP) ##1 (chip_reg == RRS_RUNNING);
	endsequence
	sequence s_chip_reset_end;
		(chip_reg == RRS_IN_RESET) ##1 (chip_reg == RRS_RUNNING);
	endsequence
	sequence s_cmd_write;
		(i_chip_reset_wr && (i_chip_reset_command_field == CHIP_RESET_CMD) && (chip_reg == RRS_RUNNING)
			&& i_supply_ok) ##1 i_supply_ok;
	endsequence

	a_port_off_early: assert property ((chip_reg != RRS_RUNNING) |=> !o_ctrl_port_en)
		else $error("control port enabled outside radio-off");
	a_wake_power_up: assert property (s_power_up_end |-> (wake_reg == WAKE_FLAGS_SET) ##1 o_irq)
		else $error("power-up end without wake flags and interrupt");
	a_wake_chip_reset: assert property (s_chip_reset_end |-> (wake_reg == WAKE_FLAGS_SET))
		else $error("chip reset end without wake flags");
	a_cmd_triggers: assert property (s_cmd_write |=> (chip_reg == RRS_IN_RESET))
		else $error("reset command did not start chip reset");
	a_reset_cause_legal: assert property ((chip_reg == RRS_RUNNING) ##1 (chip_reg == RRS_IN_RESET)
		|-> ($past(cmd_hit_reg) || $past(pin_low_sync)))
		else $error("chip reset without a valid cause");
	a_chip_clears_all: assert property ((chip_reg == RRS_IN_RESET) |=> (o_common_grp_clear
		&& o_sample_if_grp_clear && o_low_band_grp_clear && o_high_band_grp_clear))
		else $error("chip reset left a group uncleared");
	a_trx_reset_scope: assert property ((chip_reg == RRS_RUNNING && trx_reg[0] == RRS_TRX_RESET)
		|=> (o_low_band_grp_clear && !o_common_grp_clear))
		else $error("transceiver reset scope wrong");
	a_deep_keeps_common: assert property (deep_active |=> (o_sample_if_grp_clear && !o_common_grp_clear))
		else $error("deep sleep group clears wrong");
	a_pin_sync_delay: assert property (!i_hard_reset_in_low ##1 !i_hard_reset_in_low |=> pin_low_sync)
		else $error("reset pin not seen after two flops");
	a_doze_supply_off: assert property ((trx_reg[1] == RRS_TRX_DOZE) |=> !o_analog_supply_high_band_en)
		else $error("analog supply on while dozing");

endmodule // rrs_sequencer

// *** rtl/rrs_pkg.sv ***
package rrs_pkg;

	// Register groups, one clear line each.
	localparam int GRP_COMMON    = 0;
	localparam int GRP_SAMPLE_IF = 1;
	localparam int GRP_LOW_BAND  = 2;
	localparam int GRP_HIGH_BAND = 3;
	localparam int GRP_COUNT     = 4;
	localparam int TRX_COUNT     = 2;

	// Chip reset command field.
	localparam int         CHIP_RESET_CMD_W = 3;
	localparam logic [2:0] CHIP_RESET_CMD   = 3'h7;

	// Reset values.
	localparam logic [1:0] WAKE_FLAGS_RST = 2'h0;
	localparam logic [1:0] WAKE_FLAGS_SET = 2'h3;
	localparam logic       PIN_IDLE_RST   = 1'h1;

	// Timing, in nanoseconds, and the derived cycle counts at 40 MHz.
	localparam int CLK_PERIOD_NS      = 25;
	localparam int POWER_UP_DELAY_NS  = 500_000;
	localparam int CHIP_RESET_TIME_NS = 1_000;
	localparam int TRX_RESET_TIME_NS  = 500;
	localparam int POWER_UP_CYC       = (POWER_UP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CHIP_RESET_CYC     = (CHIP_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRX_RESET_CYC      = (TRX_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRX_CNT_W          = 8;

	// Chip level sequence, Gray coded along off, power-up, reset, running.
	typedef enum logic [1:0] {
		RRS_POWER_OFF = 2'h0,
		RRS_POWER_UP  = 2'h1,
		RRS_IN_RESET  = 2'h3,
		RRS_RUNNING   = 2'h2
	} rrs_chip_t;

	// Per transceiver state; code 2'h2 is unused.
	typedef enum logic [1:0] {
		RRS_TRX_RADIO_OFF = 2'h0,
		RRS_TRX_RESET     = 2'h1,
		RRS_TRX_DOZE      = 2'h3
	} rrs_trx_t;

endpackage

// *** dv/rrs_host_model.sv ***
module rrs_host_model
	import rrs_pkg::*;
(
	// Clock and device status.
	input  wire logic                            i_sys_clk,
	input  wire logic                            i_ctrl_port_en,
	// Reset pin and command write.
	output logic                                 o_hard_reset_in_low,
	output logic                                 o_chip_reset_wr,
	output logic [rrs_pkg::CHIP_RESET_CMD_W-1:0] o_chip_reset_command_field
);
	timeunit 1ns;
	timeprecision 100ps;

	// clock output unused: this host takes its clock from the testbench clock.
	initial
	begin
		o_hard_reset_in_low = 1'b1;
		o_chip_reset_wr = 1'b0;
		o_chip_reset_command_field = 3'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// Both tasks are entered right after a falling edge.
	// Waits for the port.
	task automatic write_cmd(input logic [2:0] value);
		int n;
		n = 0;
		while (i_ctrl_port_en !== 1'b1 && n < 400)
		begin
			@(negedge i_sys_clk);
			n++;
		end
		if (n < 400)
		begin
			o_chip_reset_wr = 1'b1;
			o_chip_reset_command_field = value;
			@(negedge i_sys_clk);
			o_chip_reset_wr = 1'b0;
			// The bus is driven with the inverted value, so it no longer holds the written value.
			o_chip_reset_command_field = ~value;
			// One edge passes before a following write may raise the strobe again.
			@(negedge i_sys_clk);
		end
	endtask

	task automatic pin_pulse(input int cycles);
		o_hard_reset_in_low = 1'b0;
		repeat (cycles) @(negedge i_sys_clk);
		o_hard_reset_in_low = 1'b1;
	endtask

endmodule // rrs_host_model

// *** dv/test_radio_reset_sequencer.sv ***
module test_radio_reset_sequencer;
	timeunit 1ns;
	timeprecision 100ps;
	import rrs_pkg::*;

	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       supply_ok = 1'b1;
	logic [1:0] trx_cmd = 2'h0;
	logic [1:0] doze = 2'h0;
	logic       deep = 1'b0;
	logic [3:0] events = 4'h0;
	logic [1:0] wake_clr = 2'h0;
	logic       rst_n, wr, osc, dreg, cko, an_lo, an_hi, clr_c, clr_s, clr_l, clr_h, port, irq;
	logic [2:0] field;
	logic [1:0] wake;
	logic [3:0] grp;
	int         n_fail = 0;
	int         cmp_count = 0;
	int         cyc = 0;

	assign grp = {clr_h, clr_l, clr_s, clr_c};

	initial
		forever #12.5 clk = ~clk;

	rrs_host_model host (.i_sys_clk(clk), .i_ctrl_port_en(port), .o_hard_reset_in_low(rst_n),
		.o_chip_reset_wr(wr), .o_chip_reset_command_field(field));

	// Short counts keep the run brief; the waits below have fixed limits of 400 and 100 cycles that assume them.
	rrs_sequencer #(.POWER_UP_CYCLES(20), .CHIP_RESET_CYCLES(10), .TRX_RESET_CYCLES(8)) uut (
		.i_sys_clk(clk), .i_sys_rst(rst), .i_supply_ok(supply_ok), .i_hard_reset_in_low(rst_n),
		.i_chip_reset_wr(wr), .i_chip_reset_command_field(field), .i_trx_reset_cmd(trx_cmd),
		.i_doze_req(doze), .i_deep_sleep_req(deep), .i_radio_events(events), .i_wake_clear(wake_clr),
		.o_crystal_oscillator_en(osc), .o_digital_regulator_en(dreg), .o_clock_out_en(cko),
		.o_analog_supply_low_band_en(an_lo), .o_analog_supply_high_band_en(an_hi),
		.o_common_grp_clear(clr_c), .o_sample_if_grp_clear(clr_s), .o_low_band_grp_clear(clr_l),
		.o_high_band_grp_clear(clr_h), .o_ctrl_port_en(port), .o_wake_done_flag(wake), .o_irq(irq));

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			$display("ERROR run exceeded its cycle ceiling");
			summarize();
		end
	end

	task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_port();
		int n;
		n = 0;
		while (port !== 1'b1 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		chk("ctrl_port_en", {3'h0, port}, 4'h1);
	endtask

	task automatic clear_wake();
		wake_clr = 2'h3;
		@(negedge clk);
		wake_clr = 2'h0;
		@(negedge clk);
		chk("wake cleared", {2'h0, wake}, 4'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_power_up();
		repeat (3) @(negedge clk);
		chk("osc dreg clock_out_pin port", {osc, dreg, cko, port}, 4'hC);
		chk("groups in power-up", grp, 4'hF);
		wait_port();
		chk("clock out", {3'h0, cko}, 4'h1);
		chk("wake after power-up", {1'b0, irq, wake}, 4'h7);
		chk("groups released", grp, 4'h0);
	endtask

	task automatic t_chip_reset(input bit by_pin);
		clear_wake();
		if (by_pin)
			host.pin_pulse(3);
		else
			host.write_cmd(3'h7);
		repeat (4) @(negedge clk);
		chk("port in reset", {3'h0, port}, 4'h0);
		chk("groups in reset", grp, 4'hF);
		wait_port();
		chk("wake after reset", {1'b0, irq, wake}, 4'h7);
		chk("groups after reset", grp, 4'h0);
	endtask

	task automatic t_cmd_ignored();
		clear_wake();
		for (int v = 0; v < 7; v++)
			host.write_cmd(v[2:0]);
		repeat (4) @(negedge clk);
		chk("groups other values", grp, 4'h0);
		chk("port and wake", {1'b0, port, wake}, 4'h4);
	endtask

	task automatic t_trx_reset(input int b);
		int n;
		clear_wake();
		trx_cmd[b] = 1'b1;
		@(negedge clk);
		trx_cmd = 2'h0;
		repeat (2) @(negedge clk);
		chk("band clear", grp, 4'h4 << b);
		n = 0;
		while (wake[b] !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		chk("band wake", {2'h0, wake}, 4'h1 << b);
		chk("port irq groups", {port, irq, grp[1:0]}, 4'hC);
	endtask

	task automatic t_doze(input int b);
		doze[b] = 1'b1;
		repeat (3) @(negedge clk);
		chk("analog en in doze", {2'h0, an_hi, an_lo}, b ? 4'h1 : 4'h2);
		chk("doze groups", grp, 4'h4 << b);
		doze = 2'h0;
		repeat (3) @(negedge clk);
		chk("analog en awake", {2'h0, an_hi, an_lo}, 4'h3);
		chk("groups awake", grp, 4'h0);
	endtask

	task automatic t_deep_and_irq();
		deep = 1'b1;
		repeat (3) @(negedge clk);
		chk("deep sleep groups", grp, 4'hE);
		deep = 1'b0;
		clear_wake();
		for (int i = 0; i < 4; i++)
		begin
			events = 4'h1 << i;
			repeat (2) @(negedge clk);
			chk("irq from event", {3'h0, irq}, 4'h1);
			events = 4'h0;
			repeat (2) @(negedge clk);
			chk("irq idle", {3'h0, irq}, 4'h0);
		end
	endtask

	task automatic t_supply_drop();
		supply_ok = 1'b0;
		repeat (2) @(negedge clk);
		chk("supply off", {1'b0, osc, dreg, port}, 4'h0);
		chk("supply off groups", grp, 4'hF);
		supply_ok = 1'b1;
		wait_port();
		chk("wake after supply", {1'b0, irq, wake}, 4'h7);
	endtask

	initial
	begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_power_up();
		t_cmd_ignored();
		t_chip_reset(1'b0);
		t_chip_reset(1'b1);
		t_trx_reset(0);
		t_trx_reset(1);
		t_doze(0);
		t_doze(1);
		t_deep_and_irq();
		t_supply_drop();
		summarize();
	end

endmodule // test_radio_reset_sequencer
